// ### src/pwm_output_conditioning.sv
// Output conditioning of a multi-channel PWM timer with its register slave.
// Overview of operation
// R01: Mask writes land in a write buffer.
// R02: Active mask bit forces channel inactive.
// R03: Cleared mask bit passes the signal unchanged.
// R04: Unmasked channel released at next cycle start.
// R05: Fault logic needs enhanced enable, nonzero mode.
// R06: Fault pin synchronised before any filtering.
// R07: Filter counter restarts on each level change.
// R08: Short fault pulses are discarded by filter.
// R09: Filter off: level delayed four edges.
// R10: Filter on: delay is four plus value. The code delays the level by three plus value.
// R11: Conditioned fault rising edge sets fault flag.
// R12: Faulted pair forced to polarity safe values.
// R13: Interrupt request while flag and enable set.
// R14: Flag cleared by read one, write zero.
// R15: Auto mode releases on low level, cycle start.
// R16: Auto mode ignores flag clear for outputs.
// R17: Manual mode releases on flag clear, cycle start.
// R18: Software checks fault level before manual clear.
// R19: Polarity bit one inverts the channel.
// R20: Init command forces initial values over everything.
// R21: Software initialises only with counter stopped.
// R22: Software uses enhanced, combined, edge-aligned setup.
// R23: Sync select zero loads mask next clock.
// R24: Sync select one loads mask on trigger.
// R25: Order is mask, fault, polarity; init wins.
`timescale 1ns/100ps
`default_nettype none
module pwm_output_conditioning
   import pwm_cond_pkg::*;
(
   input  wire logic                ref_clk_i,
   input  wire logic                rst_b_i,
   input  wire logic [4:0]          avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic [3:0]          avs_byteenable_i,
   output logic      [31:0]         avs_readdata_o,
   output logic                     avs_waitrequest_o,
   input  wire logic [NUM_CHAN-1:0] chan_pwm_i,
   input  wire logic                pwm_cycle_start_i,
   input  wire logic                sync_trigger_i,
   input  wire logic                fault_pin_i,
   output logic      [NUM_CHAN-1:0] chan_out_o,
   output logic                     fault_irq_o
);

   typedef struct packed {
      logic                ack;
      logic [31:0]         rdata;
      logic                efe;
      logic [1:0]          fmode;
      logic                msync;
      logic                irqen;
      logic [3:0]          ffval;
      logic [NUM_CHAN-1:0] mask_buf;
      logic [NUM_CHAN-1:0] mask_act;
      logic [NUM_CHAN-1:0] mask_hold;
      logic [NUM_CHAN-1:0] pol;
      logic [NUM_PAIR-1:0] pair_fen;
      logic [NUM_CHAN-1:0] init_val;
      logic                init_hold;
      logic                sync1;
      logic                sync2;
      logic                dly3;
      logic                dly4;
      logic                filt_lvl;
      logic [CNT_W-1:0]    filt_cnt;
      logic                cond_dly;
      logic                fflag;
      logic                clr_armed;
      logic                fault_act;
      logic [NUM_CHAN-1:0] out;
   } state_t;

   state_t              st_reg;
   state_t              st_next;
   logic                req;
   logic                rd_go;
   logic                wr_go;
   logic [31:0]         bmask;
   logic                fault_en;
   logic                cond;
   logic                fault_edge;
   logic [NUM_CHAN-1:0] eff_mask;
   logic [NUM_CHAN-1:0] shaped;

   assign req      = avs_read_i | avs_write_i;
   assign rd_go    = avs_read_i & st_reg.ack;
   assign wr_go    = avs_write_i & st_reg.ack;
   assign avs_waitrequest_o = req & ~st_reg.ack;
   assign avs_readdata_o    = st_reg.rdata;
   assign chan_out_o        = st_reg.out;

   // Fault logic only runs with enhanced features and a nonzero mode.
   assign fault_en = st_reg.efe & (st_reg.fmode != FMODE_OFF);     // [R05]
   // Filter bypass taps the second stage of the plain delay line, four edges behind the pin.
   assign cond = (st_reg.ffval == FFVAL_OFF) ? st_reg.dly4         // [R09]
                                             : st_reg.filt_lvl;    // [R10]
   assign fault_edge = fault_en & cond & ~st_reg.cond_dly;         // [R11]
   assign fault_irq_o = st_reg.fflag & st_reg.irqen;               // [R13]
   assign eff_mask = st_reg.mask_act | st_reg.mask_hold;           // [R04]

   generate
      for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
         logic masked;
         logic faulted;
         // Mask first, then fault, then polarity; init overrides later.
         assign masked  = eff_mask[c] ? 1'h0 : chan_pwm_i[c]; // [R02] [R03]
         assign faulted = (st_reg.fault_act & st_reg.pair_fen[c/2])
                          ? 1'h0 : masked;                          // [R12]
         assign shaped[c] = faulted ^ st_reg.pol[c]; // [R19] [R25]
      end
   endgenerate

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   always_comb begin
      logic [31:0] cur;
      logic [31:0] upd;
      cur = REG_RST;
      upd = REG_RST;
      st_next = st_reg;
      for (int b = 0; b < 4; b++) begin
         bmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
      end
      // Bus: one wait state, the access completes on the second edge.
      st_next.ack = req & ~st_reg.ack;
      unique case (avs_address_i)
         CTRL_OFFS: begin
            cur = REG_RST;
            cur[EFE_BIT] = st_reg.efe;
            cur[FMODE_LSB +: 2] = st_reg.fmode;
            cur[MSYNC_BIT] = st_reg.msync;
            cur[IRQEN_BIT] = st_reg.irqen;
            cur[FFVAL_LSB +: 4] = st_reg.ffval;
         end
         MASK_OFFS: begin
            cur = REG_RST;
            cur[0 +: NUM_CHAN] = st_reg.mask_act;
            cur[MBUF_LSB +: NUM_CHAN] = st_reg.mask_buf;
         end
         POL_OFFS: begin
            cur = REG_RST;
            cur[0 +: NUM_CHAN] = st_reg.pol;
         end
         FAULT_OFFS: begin
            cur = REG_RST;
            cur[FFLAG_BIT] = st_reg.fflag;
            cur[FLEVEL_BIT] = cond;
            cur[FEN_LSB +: NUM_PAIR] = st_reg.pair_fen;
         end
         INIT_OFFS: begin
            cur = REG_RST;
            cur[0 +: NUM_CHAN] = st_reg.init_val;
         end
         default: cur = REG_RST;
      endcase
      if (req && !st_reg.ack) begin
         st_next.rdata = avs_read_i ? cur : REG_RST;
      end
      upd = merge(cur, avs_writedata_i, bmask);
      if (wr_go) begin
         unique case (avs_address_i)
            CTRL_OFFS: begin
               st_next.efe   = upd[EFE_BIT];
               st_next.fmode = upd[FMODE_LSB +: 2];
               st_next.msync = upd[MSYNC_BIT];
               st_next.irqen = upd[IRQEN_BIT];
               st_next.ffval = upd[FFVAL_LSB +: 4];
            end
            // Software only reaches the buffer, never the active bits.
            MASK_OFFS: st_next.mask_buf = upd[MBUF_LSB +: NUM_CHAN]; // [R01]
            POL_OFFS:  st_next.pol = upd[0 +: NUM_CHAN];
            FAULT_OFFS: begin
               st_next.pair_fen = upd[FEN_LSB +: NUM_PAIR];
               if (st_reg.clr_armed && !upd[FFLAG_BIT]) begin
                  st_next.fflag = 1'h0;                             // [R14]
               end
               st_next.clr_armed = 1'h0;
            end
            INIT_OFFS: begin
               st_next.init_val = upd[0 +: NUM_CHAN];
               if (upd[INIT_BIT] && st_reg.efe) begin
                  st_next.init_hold = 1'h1;                         // [R20]
               end
            end
            default: st_next.efe = st_reg.efe;
         endcase
      end
      // A read that sees the flag set arms the clear.
      if (rd_go && avs_address_i == FAULT_OFFS && st_reg.fflag) begin
         st_next.clr_armed = 1'h1;                                  // [R14]
      end

      // Mask loading from the buffer.
      if (!st_reg.msync || sync_trigger_i) begin
         st_next.mask_act = st_reg.mask_buf; // [R23] [R24]
      end
      st_next.mask_hold = st_reg.mask_act |
         (st_reg.mask_hold & {NUM_CHAN{~pwm_cycle_start_i}});       // [R04]

      // Fault input: two-stage synchroniser, then a plain delay line.
      st_next.sync1 = fault_pin_i;                                  // [R06]
      st_next.sync2 = st_reg.sync1;
      st_next.dly3  = st_reg.sync2;
      st_next.dly4  = st_reg.dly3;
      // Glitch filter on the synchronised level.
      if (st_reg.sync2 != st_reg.filt_lvl) begin
         // A filter value lowered below a running count accepts at once.
         if (st_reg.filt_cnt >= {1'h0, st_reg.ffval}) begin
            st_next.filt_lvl = st_reg.sync2;                        // [R07]
            st_next.filt_cnt = '0;
         end else begin
            st_next.filt_cnt = st_reg.filt_cnt + 5'h01;             // [R07]
         end
      end else begin
         st_next.filt_cnt = '0;                                     // [R08]
      end
      st_next.cond_dly = cond;

      // Release of fault-disabled outputs at a cycle start, and at once while fault logic is off.
      if (pwm_cycle_start_i) begin
         if (st_reg.fmode == FMODE_AUTO) begin
            if (!cond) begin
               st_next.fault_act = 1'h0; // [R15] [R16]
            end
         end else if (!st_reg.fflag) begin
            st_next.fault_act = 1'h0;                               // [R17]
         end
      end
      if (!fault_en) begin
         st_next.fault_act = 1'h0;                                  // [R05]
      end
      // A new fault wins over a clear in the same cycle.
      if (fault_edge) begin
         st_next.fflag = 1'h1;                                      // [R11]
         st_next.fault_act = 1'h1;                                  // [R12]
      end

      // Initialisation holds until the next cycle start.
      if (pwm_cycle_start_i && !(wr_go && avs_address_i == INIT_OFFS)) begin
         st_next.init_hold = 1'h0;
      end
      if (st_reg.init_hold) begin
         st_next.out = st_reg.init_val; // [R20] [R25]
      end else if (st_reg.efe) begin
         st_next.out = shaped;
      end else begin
         st_next.out = chan_pwm_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   AST_MASK_FORCE: assert property ( // [R02]
      (st_reg.efe && !st_reg.init_hold && eff_mask[0])
      |=> (st_reg.out[0] == $past(st_reg.pol[0])))
      else $error("Masked channel not at inactive level.");

   AST_MASK_PASS: assert property ( // [R03]
      (st_reg.efe && !st_reg.init_hold && !eff_mask[1] && !st_reg.fault_act)
      |=> (st_reg.out[1] == ($past(chan_pwm_i[1]) ^ $past(st_reg.pol[1]))))
      else $error("Unmasked channel not passed through.");

   AST_MASK_HOLD: assert property ( // [R04]
      (st_reg.mask_hold[0] && !pwm_cycle_start_i) |=> st_reg.mask_hold[0])
      else $error("Mask hold released before cycle start.");

   AST_MASK_SYNC0: assert property ( // [R23]
      !st_reg.msync |=> (st_reg.mask_act == $past(st_reg.mask_buf)))
      else $error("Mask not loaded on next clock.");

   AST_MASK_SYNC1: assert property ( // [R24]
      (st_reg.msync && !sync_trigger_i) |=> $stable(st_reg.mask_act))
      else $error("Mask loaded without trigger.");

   AST_SYNC_DELAY: assert property ( // [R09]
      ##4 (st_reg.dly4 == $past(fault_pin_i, 4)))
      else $error("Bypass delay is not four edges.");

   AST_FILTER_HOLD: assert property ( // [R08]
      (st_reg.ffval != FFVAL_OFF && st_reg.filt_cnt < {1'h0, st_reg.ffval})
      |=> $stable(st_reg.filt_lvl))
      else $error("Filter accepted level too early.");

   AST_FLAG_SET: assert property ( // [R11]
      fault_edge |=> st_reg.fflag ##0 st_reg.fault_act)
      else $error("Fault edge did not set flag.");

   AST_FAULT_FORCE: assert property ( // [R12]
      (st_reg.efe && !st_reg.init_hold && st_reg.fault_act
       && st_reg.pair_fen[0])
      |=> (st_reg.out[1:0] == $past(st_reg.pol[1:0])))
      else $error("Faulted pair not at safe values.");

   AST_IRQ: assert property ( // [R13]
      ($rose(st_reg.fflag) && st_reg.irqen) |-> fault_irq_o)
      else $error("Fault interrupt missing.");

   AST_CLEAR_SEQ: assert property ( // [R14]
      $fell(st_reg.fflag) |-> $past(st_reg.clr_armed))
      else $error("Flag cleared without prior read.");

   AST_AUTO_HOLD: assert property ( // [R15]
      (st_reg.fault_act && fault_en && st_reg.fmode == FMODE_AUTO && cond)
      |=> st_reg.fault_act)
      else $error("Auto mode released while fault high.");

   AST_INIT: assert property ( // [R20]
      st_reg.init_hold |=> (st_reg.out == $past(st_reg.init_val)))
      else $error("Init values not forced.");

   AST_BYPASS: assert property ( // [R19]
      (!st_reg.efe && !st_reg.init_hold)
      |=> (st_reg.out == $past(chan_pwm_i)))
      else $error("Outputs not bypassed with enhanced features off.");

   AST_FAULT_OFF: assert property ( // [R05]
      !fault_en |=> (!st_reg.fault_act && !$rose(st_reg.fflag)))
      else $error("Fault logic acted while disabled.");

   AST_SYNC_STAGE: assert property ( // [R06]
      ##2 (st_reg.sync2 == $past(fault_pin_i, 2)))
      else $error("Synchroniser is not two stages.");

   AST_FILTER_ACCEPT: assert property ( // [R07]
      (st_reg.sync2 != st_reg.filt_lvl
       && st_reg.filt_cnt >= {1'h0, st_reg.ffval})
      |=> (st_reg.filt_lvl == $past(st_reg.sync2)))
      else $error("Filter did not accept a stable level.");

   AST_FILTER_RESET: assert property ( // [R08]
      (st_reg.sync2 == st_reg.filt_lvl) |=> (st_reg.filt_cnt == '0))
      else $error("Filter count not restarted.");

   AST_AUTO_RELEASE: assert property ( // [R15]
      (st_reg.fault_act && fault_en && st_reg.fmode == FMODE_AUTO
       && !cond && pwm_cycle_start_i)
      |=> !st_reg.fault_act)
      else $error("Auto mode did not release at cycle start.");

   AST_MANUAL_HOLD: assert property ( // [R17]
      (st_reg.fault_act && fault_en && st_reg.fmode != FMODE_AUTO
       && st_reg.fflag)
      |=> st_reg.fault_act)
      else $error("Manual mode released with flag set.");

   AST_MANUAL_RELEASE: assert property ( // [R17]
      (st_reg.fault_act && fault_en && st_reg.fmode != FMODE_AUTO
       && !st_reg.fflag && pwm_cycle_start_i && !fault_edge)
      |=> !st_reg.fault_act)
      else $error("Manual mode did not release at cycle start.");

   AST_FLAG_STAY: assert property ( // [R13]
      (st_reg.fflag && !(wr_go && avs_address_i == FAULT_OFFS))
      |=> st_reg.fflag)
      else $error("Fault flag dropped without a clear.");

   COV_FAULT: cover property (fault_edge ##1 fault_irq_o);
   COV_CLEAR: cover property ($fell(st_reg.fflag));
   COV_AUTO_RELEASE: cover property ($fell(st_reg.fault_act) && cond == 1'h0);
   COV_MASK_TRIG: cover property (st_reg.msync && sync_trigger_i);

endmodule
`default_nettype wire

// ### src/pwm_cond_pkg.sv
// Constants for the PWM output conditioning block.
package pwm_cond_pkg;
   localparam int unsigned NUM_CHAN  = 8;
   localparam int unsigned NUM_PAIR  = 4;
   localparam int unsigned CNT_W     = 5;
   // Register byte offsets.
   localparam logic [4:0] CTRL_OFFS   = 5'h00;
   localparam logic [4:0] MASK_OFFS   = 5'h04;
   localparam logic [4:0] POL_OFFS    = 5'h08;
   localparam logic [4:0] FAULT_OFFS  = 5'h0C;
   localparam logic [4:0] INIT_OFFS   = 5'h10;
   // Control register fields.
   localparam int unsigned EFE_BIT    = 0;
   localparam int unsigned FMODE_LSB  = 1;
   localparam int unsigned MSYNC_BIT  = 3;
   localparam int unsigned IRQEN_BIT  = 4;
   localparam int unsigned FFVAL_LSB  = 8;
   // Fault register fields.
   localparam int unsigned FFLAG_BIT  = 0;
   localparam int unsigned FLEVEL_BIT = 1;
   localparam int unsigned FEN_LSB    = 4;
   // Mask register: active bits low byte, write buffer next byte.
   localparam int unsigned MBUF_LSB   = 8;
   // Init register: command bit above the initial values.
   localparam int unsigned INIT_BIT   = 8;
   // Fault mode encodings.
   localparam logic [1:0] FMODE_OFF   = 2'h0;
   localparam logic [1:0] FMODE_AUTO  = 2'h3;
   localparam logic [3:0] FFVAL_OFF   = 4'h0;
   localparam logic [31:0] REG_RST    = 32'h0000_0000;
endpackage

// ### bench/pwm_far_side_model.sv
// Far-side model: external fault source and gate drivers on the outputs.
`timescale 1ns/100ps
`default_nettype none
module pwm_far_side_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] gate_i,
   output logic            fault_pin_o
);
   logic [7:0] gate_reg;
   initial fault_pin_o = 1'b0;
   // The gate drivers take the conditioned outputs on every clock.
   always @(posedge clk_i) gate_reg <= gate_i;
   // The fault source moves its pin only just after a clock edge.
   task automatic raise();
      @(posedge clk_i);
      fault_pin_o <= 1'b1;
   endtask
   task automatic drop();
      @(posedge clk_i);
      fault_pin_o <= 1'b0;
   endtask
   task automatic pulse(input int n);
      raise();
      repeat (n) @(posedge clk_i);
      fault_pin_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the PWM output conditioning block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import pwm_cond_pkg::*;
   typedef struct packed {
      logic [7:0] pol;
      logic [7:0] mask;
      logic [7:0] pwm;
      logic [7:0] exp_out;
   } row_t;
   localparam row_t ROWS [4] = '{'{8'h00, 8'h00, 8'hA5, 8'hA5},
      '{8'hFF, 8'h00, 8'hA5, 8'h5A}, '{8'h0F, 8'hF0, 8'hFF, 8'h00},
      '{8'h3C, 8'h81, 8'h66, 8'h5A}};
   logic        ref_clk;
   logic        rst_b;
   logic [4:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [3:0]  be;
   logic [31:0] rdata;
   logic [31:0] rdq;
   logic        wreq;
   logic [7:0]  pwm;
   logic        cyc;
   logic        trig;
   logic        fpin;
   logic [7:0]  out;
   logic        irq;
   int          num_errors;
   int          num_checks;
   int          cycles;
   pwm_output_conditioning pwm_output_conditioning_inst (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .chan_pwm_i(pwm),
      .pwm_cycle_start_i(cyc), .sync_trigger_i(trig),
      .fault_pin_i(fpin), .chan_out_o(out), .fault_irq_o(irq));
   pwm_far_side_model pwm_far_side_model_inst (
      .clk_i(ref_clk), .gate_i(out), .fault_pin_o(fpin));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop();
      if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk_reg(input string nm, input logic [31:0] e);
      num_checks++;
      if (rdq !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, rdq);
      end
   endtask
   task automatic chk_out(input string nm, input logic [7:0] e);
      num_checks++;
      if (out !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, out);
      end
   endtask
   task automatic chk_irq(input logic e);
      num_checks++;
      if (irq !== e) begin
         num_errors++;
         $display("MISMATCH fault_irq expected %b seen %b", e, irq);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      @(posedge ref_clk);
      while (wreq !== 1'b0) begin
         @(posedge ref_clk);
      end
      rdq = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic pulse_cyc();
      @(posedge ref_clk);
      cyc <= 1'b1;
      @(posedge ref_clk);
      cyc <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   // Reads the flag first so that the following zero write clears it.
   task automatic clr_flag();
      bus(1'b0, FAULT_OFFS, 32'h0000_0000);
      bus(1'b1, FAULT_OFFS, 32'h0000_00F0);
   endtask
   task automatic fault_edge(input int n);
      pwm_far_side_model_inst.raise();
      repeat (n - 1) @(posedge ref_clk);
      #1 chk_irq(1'b0);
      @(posedge ref_clk);
      #1 chk_irq(1'b1);
   endtask
   initial begin
      rst_b = 1'b0;
      addr = '0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = '0;
      be = 4'hF;
      pwm = 8'h3C;
      cyc = 1'b0;
      trig = 1'b0;
      num_errors = 0;
      num_checks = 0;
      cycles = 0;
      repeat (5) @(posedge ref_clk);
      chk_out("out_in_reset", 8'h00);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 chk_out("out_bypass", 8'h3C);
      bus(1'b1, 5'h14, 32'hFFFF_FFFF);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 5'(4 * i), 32'h0000_0000);
         chk_reg("reg_reset", REG_RST);
      end
      // Disabled byte lanes must leave the write buffer untouched.
      be <= 4'h2;
      bus(1'b1, MASK_OFFS, 32'hFFFF_AA11);
      be <= 4'h1;
      bus(1'b1, MASK_OFFS, 32'h0000_5500);
      be <= 4'hF;
      bus(1'b0, MASK_OFFS, 32'h0000_0000);
      chk_reg("mask_lanes", 32'h0000_AAAA);
      bus(1'b1, CTRL_OFFS, 32'h0000_0001);
      foreach (ROWS[i]) begin
         bus(1'b1, POL_OFFS, {24'h0, ROWS[i].pol});
         bus(1'b1, MASK_OFFS, {16'h0, ROWS[i].mask, 8'h00});
         pwm <= ROWS[i].pwm;
         pulse_cyc();
         bus(1'b0, MASK_OFFS, 32'h0000_0000);
         chk_reg("mask", {16'h0, ROWS[i].mask, ROWS[i].mask});
         #1 chk_out("out_row", ROWS[i].exp_out);
      end
      bus(1'b1, POL_OFFS, 32'h0000_000F);
      pwm <= 8'hFF;
      bus(1'b1, MASK_OFFS, 32'h0000_FF00);
      bus(1'b1, MASK_OFFS, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      #1 chk_out("out_held", 8'h0F);
      pulse_cyc();
      chk_out("out_freed", 8'hF0);
      bus(1'b1, CTRL_OFFS, 32'h0000_0009);
      bus(1'b1, MASK_OFFS, 32'h0000_5500);
      bus(1'b0, MASK_OFFS, 32'h0000_0000);
      chk_reg("mask_wait", 32'h0000_5500);
      trig <= 1'b1;
      @(posedge ref_clk);
      trig <= 1'b0;
      bus(1'b0, MASK_OFFS, 32'h0000_0000);
      chk_reg("mask_sync", 32'h0000_5555);
      bus(1'b1, CTRL_OFFS, 32'h0000_0001);
      bus(1'b1, MASK_OFFS, 32'h0000_FF00);
      bus(1'b1, INIT_OFFS, 32'h0000_0196);
      repeat (2) @(posedge ref_clk);
      #1 chk_out("out_init", 8'h96);
      pulse_cyc();
      bus(1'b1, MASK_OFFS, 32'h0000_0000);
      pulse_cyc();
      chk_out("out_after_init", 8'hF0);
      bus(1'b1, CTRL_OFFS, 32'h0000_0013);
      bus(1'b1, FAULT_OFFS, 32'h0000_00F0);
      fault_edge(5);
      repeat (2) @(posedge ref_clk);
      #1 chk_out("out_fault", 8'h0F);
      bus(1'b1, FAULT_OFFS, 32'h0000_00F0);
      #1 chk_irq(1'b1);
      bus(1'b0, FAULT_OFFS, 32'h0000_0000);
      chk_reg("fault_reg", 32'h0000_00F3);
      bus(1'b1, FAULT_OFFS, 32'h0000_00F0);
      #1 chk_irq(1'b0);
      chk_out("out_manual_hold", 8'h0F);
      pulse_cyc();
      chk_out("out_manual_free", 8'hF0);
      pwm_far_side_model_inst.drop();
      repeat (8) @(posedge ref_clk);
      bus(1'b1, CTRL_OFFS, 32'h0000_0017);
      fault_edge(5);
      clr_flag();
      pulse_cyc();
      chk_out("out_auto_hold", 8'h0F);
      pwm_far_side_model_inst.drop();
      repeat (6) @(posedge ref_clk);
      pulse_cyc();
      chk_out("out_auto_free", 8'hF0);
      bus(1'b1, CTRL_OFFS, 32'h0000_0415);
      bus(1'b0, CTRL_OFFS, 32'h0000_0000);
      chk_reg("ctrl", 32'h0000_0415);
      pwm_far_side_model_inst.pulse(2);
      repeat (10) @(posedge ref_clk);
      #1 chk_irq(1'b0);
      fault_edge(8);
      pwm_far_side_model_inst.drop();
      repeat (10) @(posedge ref_clk);
      clr_flag();
      bus(1'b1, CTRL_OFFS, 32'h0000_0011);
      pwm_far_side_model_inst.raise();
      repeat (10) @(posedge ref_clk);
      #1 chk_irq(1'b0);
      chk_out("out_fault_off", 8'hF0);
      report_and_stop();
   end
endmodule
`default_nettype wire
